// ==== design/fsc_regs.sv ====
// Segment extension and configuration registers of the serial flash
// How it works
// RL1: In three-byte mode extension bit zero becomes array address bit 24.
// RL2: Extension register acts as fourth address byte; upper seven bits stay zero.
// RL3: Four-byte mode ignores the extension register; command supplies every address bit.
// RL4: Persistent bit 1 picks start segment: 0 upper half, 1 lower half.
// RL5: Program and sector erase stay in selected segment; bulk erase clears everything.
// RL6: Continuous read runs into next segment and wraps to zero at array end.
// RL7: Extension register never changes when a read crosses a segment boundary.
// RL8: Working configuration lives in an internal register the host cannot reach.
// RL9: Power-on and every reset copy persistent configuration into the working register.
// RL10: Finished volatile or enhanced volatile writes load the working register at once.
// RL11: Persistent register is reached only by its own read and write commands.
// RL12: Bits 15:12 give dummy cycles 1 to 14; 0000 acts as 1111 default.
// RL13: Bits 11:9 pick power-on execute-in-place read type; 111 and reserved disable.
// RL14: Bit 5 cleared turns on double transfer rate for every command.
// RL15: Bit 4 set lets data line three act as hold or reset.
// RL16: Bit 3 cleared enables four-line command, address and data transfer.
// RL17: Bit 2 cleared enables two-line command, address and data transfer.
// RL18: Bit 0 picks address length: 0 four bytes, 1 three bytes.
// RL19: With bits 2 and 3 both cleared the four-line protocol wins.
// RL20: Writes to reserved extension bits are dropped so they read zero.
`timescale 1ns/10ps
`default_nettype none
`include "fsc_map.svh"
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int ADDR_W = 25                       // Array address width
) (
  input  wire logic              clk,             // Core clock
  input  wire logic              rst,             // Core reset, active high
  input  wire logic              lk_clk,          // Serial link clock
  input  wire logic              lk_rst,          // Link reset, active high
  input  wire logic              lk_cmd_valid,    // Command strobe on link clock
  input  var  fsc_cmd_t          lk_cmd_kind,     // Decoded command
  input  wire logic [31:0]       lk_cmd_addr,     // Command address bytes
  input  wire logic [15:0]       lk_cmd_wdata,    // Register write data
  output logic                   lk_busy,         // Command in flight
  output logic                   lk_done,         // Command finished pulse
  output logic      [15:0]       lk_rd_data,      // Register read answer
  input  wire logic              mem_rd_next,     // Datapath took one read byte
  output logic                   mem_op_valid,    // Array operation pulse
  output fsc_op_t                mem_op,          // Array operation kind
  output logic      [ADDR_W-1:0] mem_addr,        // Array address
  output logic      [3:0]        cfg_dummy,       // Dummy cycle count
  output logic                   cfg_xip_en,      // Execute-in-place active
  output logic      [2:0]        cfg_xip_mode,    // Execute-in-place read type
  output logic                   cfg_dtr_en,      // Double transfer rate
  output logic                   cfg_hold_en,     // Hold or reset on data line three
  output logic                   cfg_quad_en,     // Four-line protocol
  output logic                   cfg_dual_en,     // Two-line protocol
  output logic                   cfg_addr4,       // Four-byte addressing
  output logic      [1:0]        cfg_wrap         // Read wrap mode
);

  // Decode of the persistent register into working settings
  function automatic fsc_icr_t fsc_from_nv(input logic [15:0] nv);
    fsc_icr_t r;
    r.dummy    = nv[`FSC_NV_DUMMY_HI:`FSC_NV_DUMMY_LO];
    if (r.dummy == `FSC_DUMMY_ALIAS) begin
      r.dummy = `FSC_DUMMY_DEFAULT; // RL12
    end
    r.xip_mode = nv[`FSC_NV_XIP_HI:`FSC_NV_XIP_LO];
    r.xip_en   = (r.xip_mode <= `FSC_XIP_LAST); // RL13
    r.dtr_en   = ~nv[`FSC_NV_DTR]; // RL14
    r.hold_en  = nv[`FSC_NV_HOLD]; // RL15
    r.quad_en  = ~nv[`FSC_NV_QUAD]; // RL16
    r.dual_en  = ~nv[`FSC_NV_DUAL] & nv[`FSC_NV_QUAD]; // RL17 RL19
    r.addr4    = ~nv[`FSC_NV_ADDR]; // RL18
    r.wrap     = `FSC_WRAP_CONT;
    return r;
  endfunction

  // Power-on persistent value as a named constant, so its segment bit can be picked out
  localparam logic [15:0] NV_RST = `FSC_NV_RESET;

  // Link domain
  fsc_lk_state_t lk_state_ff;
  fsc_lk_state_t nxt_lk_state;
  logic          lk_req_ff;
  fsc_cmd_t      lk_kind_ff;
  logic [31:0]   lk_addr_ff;
  logic [15:0]   lk_wdata_ff;
  logic          lk_done_ff;
  logic [15:0]   lk_rd_data_ff;
  logic          lk_ack_q;
  logic          lk_take;
  logic          lk_fin;

  // Acknowledge toggle coming back from the core
  logic          ack_ff;
  fsc_sync u_ack_sync (
    .clk (lk_clk),
    .rst (lk_rst),
    .d   (ack_ff),
    .q   (lk_ack_q)
  );

  // Command held still until the core answers
  assign lk_take = (lk_state_ff == FSC_LK_IDLE) & lk_cmd_valid;
  assign lk_fin  = (lk_state_ff == FSC_LK_WAIT) & (lk_ack_q == lk_req_ff);

  always_comb begin
    nxt_lk_state = lk_state_ff;
    case (lk_state_ff)
      FSC_LK_IDLE: begin
        if (lk_take) begin
          nxt_lk_state = FSC_LK_WAIT;
        end
      end
      FSC_LK_WAIT: begin
        if (lk_fin) begin
          nxt_lk_state = FSC_LK_IDLE;
        end
      end
      default: begin
        nxt_lk_state = FSC_LK_IDLE;
      end
    endcase
  end

  // Capture of one command per handshake
  always_ff @(posedge lk_clk) begin
    if (lk_rst) begin
      lk_state_ff <= FSC_LK_IDLE;
      lk_req_ff   <= 1'b0;
      lk_kind_ff  <= FSC_CMD_NOP;
      lk_addr_ff  <= 32'h00000000;
      lk_wdata_ff <= 16'h0000;
    end else begin
      lk_state_ff <= nxt_lk_state;
      if (lk_take) begin
        lk_req_ff   <= ~lk_req_ff;
        lk_kind_ff  <= lk_cmd_kind;
        lk_addr_ff  <= lk_cmd_addr;
        lk_wdata_ff <= lk_cmd_wdata;
      end
    end
  end

  // Answer is stable in the core while the request stays unchanged
  logic [15:0] rsp_ff;
  always_ff @(posedge lk_clk) begin
    if (lk_rst) begin
      lk_done_ff    <= 1'b0;
      lk_rd_data_ff <= 16'h0000;
    end else begin
      lk_done_ff <= lk_fin;
      if (lk_fin) begin
        lk_rd_data_ff <= rsp_ff;
      end
    end
  end

  assign lk_busy    = (lk_state_ff == FSC_LK_WAIT);
  assign lk_done    = lk_done_ff;
  assign lk_rd_data = lk_rd_data_ff;

  // Core domain
  logic              req_q;
  logic              new_req;
  logic [15:0]       nv_ff;
  logic [7:0]        vcr_ff;
  logic [7:0]        evcr_ff;
  logic [7:0]        ext_ff;
  fsc_icr_t          icr_ff;
  fsc_icr_t          nxt_icr;
  logic              op_valid_ff;
  fsc_op_t           op_ff;
  fsc_op_t           nxt_op;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [15:0]       nxt_rsp;
  logic [3:0]        vcr_dummy;

  fsc_sync u_req_sync (
    .clk (clk),
    .rst (rst),
    .d   (lk_req_ff),
    .q   (req_q)
  );

  fsc_addr_gen #(
    .ADDR_W (ADDR_W)
  ) u_addr_gen (
    .cmd_addr   (lk_addr_ff),
    .addr4      (icr_ff.addr4),
    .seg_sel    (ext_ff[0]),
    .cur_addr   (addr_ff),
    .wrap       (icr_ff.wrap),
    .start_addr (start_addr),
    .next_addr  (next_addr)
  );

  // A toggle mismatch marks one fresh, stable command
  assign new_req   = (req_q != ack_ff);
  assign vcr_dummy = (lk_wdata_ff[`FSC_VCR_DUMMY_HI:`FSC_VCR_DUMMY_LO] == `FSC_DUMMY_ALIAS)
                   ? `FSC_DUMMY_DEFAULT
                   : lk_wdata_ff[`FSC_VCR_DUMMY_HI:`FSC_VCR_DUMMY_LO]; // RL12

  // Read answers; the working register has no path here
  assign nxt_rsp = (lk_kind_ff == FSC_CMD_RD_EXT)  ? {8'h00, ext_ff} // RL2 RL8
                 : (lk_kind_ff == FSC_CMD_RD_NV)   ? nv_ff // RL11
                 : (lk_kind_ff == FSC_CMD_RD_VOL)  ? {8'h00, vcr_ff}
                 : (lk_kind_ff == FSC_CMD_RD_EVOL) ? {8'h00, evcr_ff}
                 : 16'h0000;

  // Working register updates per command
  always_comb begin
    nxt_icr = icr_ff;
    nxt_op  = FSC_OP_NONE;
    if (new_req) begin
      case (lk_kind_ff)
        FSC_CMD_WR_VOL: begin
          nxt_icr.dummy  = vcr_dummy; // RL10
          nxt_icr.xip_en = ~lk_wdata_ff[`FSC_VCR_XIP];
          nxt_icr.wrap   = lk_wdata_ff[`FSC_VCR_WRAP_HI:`FSC_VCR_WRAP_LO];
        end
        FSC_CMD_WR_EVOL: begin
          nxt_icr.quad_en = ~lk_wdata_ff[`FSC_EVCR_QUAD]; // RL10
          nxt_icr.dual_en = ~lk_wdata_ff[`FSC_EVCR_DUAL] & lk_wdata_ff[`FSC_EVCR_QUAD];
          nxt_icr.dtr_en  = ~lk_wdata_ff[`FSC_EVCR_DTR];
          nxt_icr.hold_en = lk_wdata_ff[`FSC_EVCR_HOLD];
          nxt_icr.addr4   = ~lk_wdata_ff[`FSC_EVCR_ADDR];
        end
        FSC_CMD_EN4B: begin
          nxt_icr.addr4 = 1'b1; // RL3
        end
        FSC_CMD_EX4B: begin
          nxt_icr.addr4 = 1'b0;
        end
        FSC_CMD_RESET: begin
          nxt_icr = fsc_from_nv(nv_ff); // RL9
        end
        FSC_CMD_READ: begin
          nxt_op = FSC_OP_READ; // RL6
        end
        FSC_CMD_PROG: begin
          nxt_op = FSC_OP_PROG; // RL5
        end
        FSC_CMD_SECT_ER: begin
          nxt_op = FSC_OP_SECT_ER; // RL5
        end
        FSC_CMD_BULK_ER: begin
          nxt_op = FSC_OP_BULK_ER; // RL5
        end
        default: begin
          nxt_icr = icr_ff;
        end
      endcase
    end
  end

  // Handshake and working register
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rsp_ff <= 16'h0000;
      icr_ff <= fsc_from_nv(`FSC_NV_RESET); // RL9
    end else begin
      icr_ff <= nxt_icr;
      if (new_req) begin
        ack_ff <= req_q;
        rsp_ff <= nxt_rsp;
      end
    end
  end

  // Host visible registers; persistent value survives the reset command
  always_ff @(posedge clk) begin
    if (rst) begin
      nv_ff   <= `FSC_NV_RESET;
      vcr_ff  <= `FSC_VCR_RESET;
      evcr_ff <= `FSC_EVCR_RESET;
      ext_ff  <= {7'h00, ~NV_RST[`FSC_NV_SEG]}; // RL4
    end else if (new_req) begin
      case (lk_kind_ff)
        FSC_CMD_WR_NV: begin
          nv_ff <= lk_wdata_ff; // RL11
        end
        // Reserved volatile bit is forced to zero
        FSC_CMD_WR_VOL: begin
          vcr_ff <= lk_wdata_ff[7:0] & ~8'h04;
        end
        FSC_CMD_WR_EVOL: begin
          evcr_ff <= lk_wdata_ff[7:0] & `FSC_EVCR_MASK;
        end
        FSC_CMD_WR_EXT: begin
          ext_ff <= lk_wdata_ff[7:0] & `FSC_EXT_MASK; // RL2 RL20
        end
        FSC_CMD_RESET: begin
          vcr_ff  <= `FSC_VCR_RESET;
          evcr_ff <= `FSC_EVCR_RESET;
          ext_ff  <= {7'h00, ~nv_ff[`FSC_NV_SEG]}; // RL4 RL9
        end
        default: begin
          ext_ff <= ext_ff;
        end
      endcase
    end
  end

  // Array operation; reads advance here and leave the extension alone
  always_ff @(posedge clk) begin
    if (rst) begin
      op_valid_ff <= 1'b0;
      op_ff       <= FSC_OP_NONE;
      addr_ff     <= '0;
    end else begin
      op_valid_ff <= (nxt_op != FSC_OP_NONE);
      if (nxt_op == FSC_OP_BULK_ER) begin
        op_ff   <= nxt_op;
        addr_ff <= '0; // RL5
      end else if (nxt_op != FSC_OP_NONE) begin
        op_ff   <= nxt_op;
        addr_ff <= start_addr; // RL5
      end else if (mem_rd_next && (op_ff == FSC_OP_READ)) begin
        addr_ff <= next_addr; // RL6 RL7
      end
    end
  end

  assign mem_op_valid = op_valid_ff;
  assign mem_op       = op_ff;
  assign mem_addr     = addr_ff;
  assign cfg_dummy    = icr_ff.dummy;
  assign cfg_xip_en   = icr_ff.xip_en;
  assign cfg_xip_mode = icr_ff.xip_mode;
  assign cfg_dtr_en   = icr_ff.dtr_en;
  assign cfg_hold_en  = icr_ff.hold_en;
  assign cfg_quad_en  = icr_ff.quad_en;
  assign cfg_dual_en  = icr_ff.dual_en;
  assign cfg_addr4    = icr_ff.addr4;
  assign cfg_wrap     = icr_ff.wrap;

endmodule
`default_nettype wire

// ==== design/fsc_map.svh ====
// Field positions, reset values and masks of the flash segment and configuration registers
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// Persistent configuration fields
`define FSC_NV_RESET      16'hFFFF
`define FSC_NV_DUMMY_HI   15
`define FSC_NV_DUMMY_LO   12
`define FSC_NV_XIP_HI     11
`define FSC_NV_XIP_LO     9
`define FSC_NV_DTR        5
`define FSC_NV_HOLD       4
`define FSC_NV_QUAD       3
`define FSC_NV_DUAL       2
`define FSC_NV_SEG        1
`define FSC_NV_ADDR       0

// Volatile configuration fields
`define FSC_VCR_RESET     8'hFB
`define FSC_VCR_DUMMY_HI  7
`define FSC_VCR_DUMMY_LO  4
`define FSC_VCR_XIP       3
`define FSC_VCR_RSVD      2
`define FSC_VCR_WRAP_HI   1
`define FSC_VCR_WRAP_LO   0

// Enhanced volatile configuration fields
`define FSC_EVCR_RESET    8'hF1
`define FSC_EVCR_QUAD     7
`define FSC_EVCR_DUAL     6
`define FSC_EVCR_DTR      5
`define FSC_EVCR_HOLD     4
`define FSC_EVCR_ADDR     0
`define FSC_EVCR_MASK     8'hF1

// Encodings
`define FSC_DUMMY_ALIAS   4'h0
`define FSC_DUMMY_DEFAULT 4'hF
`define FSC_XIP_LAST      3'h4
`define FSC_WRAP_CONT     2'h3
`define FSC_EXT_MASK      8'h01

`endif

// ==== design/fsc_pkg.sv ====
// Types shared by the flash segment and configuration logic
package fsc_pkg;

  // Decoded host commands arriving on the link
  typedef enum logic [3:0] {
    FSC_CMD_NOP     = 4'h0,
    FSC_CMD_RD_EXT  = 4'h1,
    FSC_CMD_WR_EXT  = 4'h2,
    FSC_CMD_RD_NV   = 4'h3,
    FSC_CMD_WR_NV   = 4'h4,
    FSC_CMD_RD_VOL  = 4'h5,
    FSC_CMD_WR_VOL  = 4'h6,
    FSC_CMD_RD_EVOL = 4'h7,
    FSC_CMD_WR_EVOL = 4'h8,
    FSC_CMD_EN4B    = 4'h9,
    FSC_CMD_EX4B    = 4'hA,
    FSC_CMD_READ    = 4'hB,
    FSC_CMD_PROG    = 4'hC,
    FSC_CMD_SECT_ER = 4'hD,
    FSC_CMD_BULK_ER = 4'hE,
    FSC_CMD_RESET   = 4'hF
  } fsc_cmd_t;

  // Operations handed to the array datapath
  typedef enum logic [2:0] {
    FSC_OP_NONE    = 3'h0,
    FSC_OP_READ    = 3'h1,
    FSC_OP_PROG    = 3'h2,
    FSC_OP_SECT_ER = 3'h3,
    FSC_OP_BULK_ER = 3'h4
  } fsc_op_t;

  // Link side handshake states
  typedef enum logic [0:0] {
    FSC_LK_IDLE = 1'b0,
    FSC_LK_WAIT = 1'b1
  } fsc_lk_state_t;

  // Internal configuration, never visible to the host
  typedef struct packed {
    logic [3:0] dummy;
    logic       xip_en;
    logic [2:0] xip_mode;
    logic       dtr_en;
    logic       hold_en;
    logic       quad_en;
    logic       dual_en;
    logic       addr4;
    logic [1:0] wrap;
  } fsc_icr_t;

endpackage

// ==== design/fsc_sync.sv ====
// Three-stage level synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module fsc_sync (
  input  wire logic clk,  // Destination clock
  input  wire logic rst,  // Synchronous reset, active high
  input  wire logic d,    // Level from the other domain
  output logic      q     // Filtered level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_ff  <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end

  assign q = q_ff;

endmodule
`default_nettype wire

// ==== design/fsc_addr_gen.sv ====
// Array address forming and read sequencing
`timescale 1ns/10ps
`default_nettype none
module fsc_addr_gen #(
  parameter int ADDR_W = 25              // Array address width
) (
  input  wire logic [31:0]       cmd_addr,   // Address from the command
  input  wire logic              addr4,      // Four-byte addressing active
  input  wire logic              seg_sel,    // Segment select bit
  input  wire logic [ADDR_W-1:0] cur_addr,   // Current read address
  input  wire logic [1:0]        wrap,       // Read wrap mode
  output logic      [ADDR_W-1:0] start_addr, // First array address
  output logic      [ADDR_W-1:0] next_addr   // Following read address
);

  logic [ADDR_W-1:0] inc_addr;
  logic [ADDR_W-1:0] wrap_mask;

  // Segment bit replaces the top bit only for three-byte commands
  assign start_addr = addr4 ? cmd_addr[ADDR_W-1:0] // RL3
                            : {seg_sel, cmd_addr[ADDR_W-2:0]}; // RL1

  // Natural overflow takes the pointer back to zero at the array end
  assign inc_addr  = ADDR_W'(cur_addr + 1'b1); // RL6
  assign wrap_mask = (wrap == 2'h0) ? ADDR_W'(8'h0F)
                   : (wrap == 2'h1) ? ADDR_W'(8'h1F)
                   : ADDR_W'(8'h3F);
  assign next_addr = (wrap == `FSC_WRAP_CONT) ? inc_addr // RL6
                   : ((cur_addr & ~wrap_mask) | (inc_addr & wrap_mask));

endmodule
`default_nettype wire

// ==== verif/fsc_regs_checker.sv ====
// Port assertions for the flash segment and configuration registers
`timescale 1ns/10ps
`default_nettype none
module fsc_regs_checker
  import fsc_pkg::*;
#(
  parameter int ADDR_W = 25                   // Array address width
) (
  input  wire logic              clk,          // Core clock
  input  wire logic              rst,          // Core reset
  input  wire logic              lk_clk,       // Link clock
  input  wire logic              lk_rst,       // Link reset
  input  wire logic              lk_busy,      // Command in flight
  input  wire logic              lk_done,      // Finish pulse
  input  wire logic              mem_rd_next,  // Read byte taken
  input  wire logic              mem_op_valid, // Operation pulse
  input  var  fsc_op_t           mem_op,       // Operation kind
  input  wire logic [ADDR_W-1:0] mem_addr,     // Array address
  input  wire logic [3:0]        cfg_dummy,    // Dummy cycles
  input  wire logic              cfg_hold_en,  // Hold function
  input  wire logic              cfg_quad_en,  // Four-line
  input  wire logic              cfg_dual_en,  // Two-line
  input  wire logic              cfg_addr4,    // Four-byte mode
  input  wire logic [1:0]        cfg_wrap      // Wrap mode
);
  // Link handshake: every command must be answered, a hang shows first in the host's 20-cycle timeout
  a_done_one_pulse: assert property (@(posedge lk_clk) disable iff (lk_rst)
    lk_done |=> !lk_done) else $error("done pulse too long");
  a_busy_gets_done: assert property (@(posedge lk_clk) disable iff (lk_rst)
    $rose(lk_busy) |-> ##[1:25] lk_done) else $error("busy never answered");
  a_done_ends_busy: assert property (@(posedge lk_clk) disable iff (lk_rst)
    lk_done |-> !lk_busy) else $error("busy still high at done");
  // Core side operations and configuration
  a_op_one_pulse: assert property (@(posedge clk) disable iff (rst)
    mem_op_valid |=> !mem_op_valid) else $error("operation pulse too long");
  a_bulk_from_zero: assert property (@(posedge clk) disable iff (rst)
    mem_op_valid && mem_op == FSC_OP_BULK_ER |-> mem_addr == '0) else $error("bulk not at zero");
  a_dummy_not_zero: assert property (@(posedge clk) disable iff (rst)
    cfg_dummy != 4'h0) else $error("dummy code zero shown");
  a_quad_beats_dual: assert property (@(posedge clk) disable iff (rst)
    cfg_quad_en |-> !cfg_dual_en) else $error("dual with quad");
  a_reset_loads_cfg: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> cfg_dummy == 4'hF && cfg_hold_en && !cfg_addr4 && mem_op == FSC_OP_NONE)
    else $error("configuration not reloaded");
  a_read_steps_on: assert property (@(posedge clk) disable iff (rst)
    mem_op == FSC_OP_READ && mem_rd_next && cfg_wrap == 2'h3 && !mem_op_valid
    |=> mem_op_valid || mem_addr == ADDR_W'($past(mem_addr) + 1)) else $error("read did not step");
  // Main scenarios reached
  c_bulk: cover property (@(posedge clk) mem_op_valid && mem_op == FSC_OP_BULK_ER);
  c_step: cover property (@(posedge clk) mem_op == FSC_OP_READ && mem_rd_next);
  c_quad: cover property (@(posedge clk) cfg_quad_en);
endmodule
`default_nettype wire

// ==== verif/fsc_host.sv ====
// Host controller model issuing register and array commands on the link
`timescale 1ns/10ps
`default_nettype none
module fsc_host
  import fsc_pkg::*;
(
  input  wire logic        lk_clk,       // Link clock
  input  wire logic        lk_done,      // Finish pulse
  input  wire logic [15:0] lk_rd_data,   // Read answer
  output logic             lk_cmd_valid, // Command strobe
  output var  fsc_cmd_t    lk_cmd_kind,  // Command kind
  output logic      [31:0] lk_cmd_addr,  // Address bytes
  output logic      [15:0] lk_cmd_wdata  // Write data
);
  initial begin
    lk_cmd_valid = 1'b0;
    lk_cmd_kind  = FSC_CMD_NOP;
    lk_cmd_addr  = '0;
    lk_cmd_wdata = '0;
  end
  // One command, registers only through their own kinds; stale fields inverted after take
  task automatic send(input fsc_cmd_t k, input logic [31:0] a, input logic [15:0] w,
                      output logic [15:0] rd, output logic ok);
    int n;
    @(posedge lk_clk);
    #1;
    lk_cmd_valid = 1'b1;
    lk_cmd_kind  = k;
    lk_cmd_addr  = a;
    lk_cmd_wdata = w;
    @(posedge lk_clk);
    #1;
    lk_cmd_valid = 1'b0;
    lk_cmd_addr  = ~a;
    lk_cmd_wdata = ~w;
    n = 0;
    while (lk_done !== 1'b1 && n < 20) begin
      @(posedge lk_clk);
      #1;
      n++;
    end
    rd = lk_rd_data;
    ok = (lk_done === 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== verif/fsc_regs_tb.sv ====
// Self-checking bench for the flash segment and configuration registers
`timescale 1ns/10ps
`default_nettype none
module fsc_regs_tb;
  import fsc_pkg::*;
  logic clk = 1'b0, lk_clk = 1'b0, rst = 1'b1, lk_rst = 1'b1, mem_rd_next = 1'b0;
  logic lk_cmd_valid, lk_busy, lk_done, mem_op_valid, ok;
  logic cfg_xip_en, cfg_dtr_en, cfg_hold_en, cfg_quad_en, cfg_dual_en, cfg_addr4;
  logic [31:0] lk_cmd_addr;
  logic [15:0] lk_cmd_wdata, lk_rd_data, rd;
  logic [24:0] mem_addr;
  logic [3:0]  cfg_dummy;
  logic [2:0]  cfg_xip_mode;
  logic [1:0]  cfg_wrap;
  fsc_cmd_t    lk_cmd_kind;
  fsc_op_t     mem_op;
  int bad_count = 0, total_checks = 0;
  logic [15:0] nv_tab [8] = '{16'h0808, 16'h7FF3, 16'hE1FF, 16'hE3FF, 16'hE5FF, 16'hE7FF,
                              16'hEBFF, 16'hFFFF};
  wire logic [14:0] icr = {cfg_dummy, cfg_xip_en, cfg_xip_mode, cfg_dtr_en, cfg_hold_en,
                           cfg_quad_en, cfg_dual_en, cfg_addr4, cfg_wrap};

  // Clocks unrelated in phase
  always #20 clk = ~clk;
  always #15 lk_clk = ~lk_clk;

  fsc_regs fsc_regs_inst (.clk, .rst, .lk_clk, .lk_rst, .lk_cmd_valid, .lk_cmd_kind,
    .lk_cmd_addr, .lk_cmd_wdata, .lk_busy, .lk_done, .lk_rd_data, .mem_rd_next, .mem_op_valid,
    .mem_op, .mem_addr, .cfg_dummy, .cfg_xip_en, .cfg_xip_mode, .cfg_dtr_en, .cfg_hold_en,
    .cfg_quad_en, .cfg_dual_en, .cfg_addr4, .cfg_wrap);
  fsc_host fsc_host_inst (.lk_clk, .lk_done, .lk_rd_data, .lk_cmd_valid, .lk_cmd_kind,
    .lk_cmd_addr, .lk_cmd_wdata);

  // Expected working configuration after a reload from a persistent value
  function automatic logic [14:0] icr_of(input logic [15:0] nv);
    return {(nv[15:12] == 4'h0) ? 4'hF : nv[15:12], nv[11:9] <= 3'h4, nv[11:9], ~nv[5],
            nv[4], ~nv[3], ~nv[2] & nv[3], ~nv[0], 2'h3};
  endfunction

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A hung command counts as a mismatch and ends the run
  task automatic cmd(input fsc_cmd_t k, input logic [31:0] a, input logic [15:0] w);
    fsc_host_inst.send(k, a, w, rd, ok);
    if (!ok) begin
      bad_count++;
      close_out();
    end
  endtask

  // Array command, then the operation kind and address it produced
  task automatic op(input fsc_cmd_t k, input logic [31:0] a, input fsc_op_t eo,
                    input logic [24:0] ea);
    cmd(k, a, 16'h0000);
    check(32'(mem_op), 32'(eo));
    check(32'(mem_addr), 32'(ea));
  endtask

  // One byte consumed by the datapath
  task automatic step_read();
    @(posedge clk);
    #1;
    mem_rd_next = 1'b1;
    @(posedge clk);
    #1;
    mem_rd_next = 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge lk_clk);
    #1;
    lk_rst = 1'b0;
    repeat (3) @(posedge lk_clk);
    check(32'(icr), 32'(icr_of(16'hFFFF)));
    // Persistent values reloaded by soft reset, segment taken from bit 1
    foreach (nv_tab[i]) begin
      cmd(FSC_CMD_WR_NV, 32'h0, nv_tab[i]);
      cmd(FSC_CMD_RD_NV, 32'h0, 16'h0);
      check(32'(rd), 32'(nv_tab[i]));
      cmd(FSC_CMD_RESET, 32'h0, 16'h0);
      check(32'(icr), 32'(icr_of(nv_tab[i])));
      cmd(FSC_CMD_RD_EXT, 32'h0, 16'h0);
      check(32'(rd), {31'h0, ~nv_tab[i][1]});
    end
    cmd(FSC_CMD_WR_EXT, 32'h0, 16'h00FF);
    cmd(FSC_CMD_RD_EXT, 32'h0, 16'h0);
    check(32'(rd), 32'h1);
    op(FSC_CMD_PROG, 32'hAA123456, FSC_OP_PROG, 25'h1123456);
    op(FSC_CMD_SECT_ER, 32'h00654321, FSC_OP_SECT_ER, 25'h1654321);
    op(FSC_CMD_BULK_ER, 32'h00654321, FSC_OP_BULK_ER, 25'h0000000);
    // Continuous read past the top wraps to zero, extension untouched
    op(FSC_CMD_READ, 32'h00FFFFFF, FSC_OP_READ, 25'h1FFFFFF);
    step_read();
    check(32'(mem_addr), 32'h0);
    cmd(FSC_CMD_RD_EXT, 32'h0, 16'h0);
    check(32'(rd), 32'h1);
    cmd(FSC_CMD_EN4B, 32'h0, 16'h0);
    check(32'(cfg_addr4), 32'h1);
    op(FSC_CMD_PROG, 32'h000ABCDE, FSC_OP_PROG, 25'h00ABCDE);
    cmd(FSC_CMD_EX4B, 32'h0, 16'h0);
    cmd(FSC_CMD_WR_EXT, 32'h0, 16'h0000);
    op(FSC_CMD_READ, 32'h00FFFFFF, FSC_OP_READ, 25'h0FFFFFF);
    step_read();
    check(32'(mem_addr), 32'h1000000);
    // Volatile writes take effect at once
    cmd(FSC_CMD_WR_VOL, 32'h0, 16'h0024);
    check(32'({cfg_dummy, cfg_xip_en, cfg_wrap}), 32'h14);
    cmd(FSC_CMD_RD_VOL, 32'h0, 16'h0);
    check(32'(rd), 32'h20);
    // Sixteen-byte wrap now active: the read stays in its aligned block
    op(FSC_CMD_READ, 32'h0000001F, FSC_OP_READ, 25'h000001F);
    step_read();
    check(32'(mem_addr), 32'h10);
    cmd(FSC_CMD_WR_EVOL, 32'h0, 16'h0000);
    check(32'({cfg_dtr_en, cfg_hold_en, cfg_quad_en, cfg_dual_en, cfg_addr4}), 32'h15);
    // Both resets again in mid-run; together, so the toggles stay paired
    @(posedge clk);
    #1;
    rst = 1'b1;
    lk_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    lk_rst = 1'b0;
    @(posedge clk);
    check(32'(icr), 32'(icr_of(16'hFFFF)));
    close_out();
  end
endmodule

bind fsc_regs fsc_regs_checker #(.ADDR_W(ADDR_W)) fsc_regs_checker_inst (.clk, .rst, .lk_clk,
  .lk_rst, .lk_busy, .lk_done, .mem_rd_next, .mem_op_valid, .mem_op, .mem_addr, .cfg_dummy,
  .cfg_hold_en, .cfg_quad_en, .cfg_dual_en, .cfg_addr4, .cfg_wrap);
`default_nettype wire
